// ==== szac_defines.svh ====
// Purpose: shared constants of the secure zone access control block
// Assumes: included by bare name, once per compilation unit
// Notes:   counts and codes only, types live in szac_pkg
`ifndef SZAC_DEFINES_SVH
`define SZAC_DEFINES_SVH
`define SZAC_PWD_SETS    8
`define SZAC_KEYS        4
`define SZAC_TRY_CNTS    12
`define SZAC_KEY_BASE    4'h8
`define SZAC_TRY_LIMIT   3'h4
`define SZAC_AT_MAX      4'h8
`define SZAC_SECURE_CODE 24'h22ef67
`define SZAC_LINK_WAKE   3'h5
`endif

// ==== szac_pkg.sv ====
// Purpose: types of the secure zone access control block
// Assumes: szac_defines.svh holds the numbers
// Notes:   all users write szac_pkg::name
package szac_pkg;
  typedef enum logic [2:0] {
    OP_READ   = 3'h0,
    OP_WRITE  = 3'h1,
    OP_PWD    = 3'h2,
    OP_AUTH   = 3'h3,
    OP_MACCHK = 3'h4,
    OP_SECURE = 3'h5,
    OP_CFG_RD = 3'h6,
    OP_CFG_WR = 3'h7
  } szac_op_t;
  typedef enum logic [1:0] {
    MODE_STD  = 2'h0,
    MODE_AUTH = 2'h1,
    MODE_ENC  = 2'h2
  } szac_mode_t;
  typedef enum logic [1:0] {
    AT_IDLE    = 2'h0,
    AT_BUF     = 2'h1,
    AT_COPY    = 2'h2,
    AT_RECOVER = 2'h3
  } szac_at_state_t;
  typedef enum logic [1:0] {
    NVM_NONE    = 2'h0,
    NVM_TO_BUF  = 2'h1,
    NVM_TO_DEST = 2'h2,
    NVM_RESTORE = 2'h3
  } szac_nvm_op_t;
  typedef struct packed {
    szac_op_t    op;
    logic [2:0]  set;
    logic        rd_pwd;
    logic        want_enc;
    logic [2:0]  addr_lo;
    logic        first;
    logic        last;
    logic [7:0]  data;
    logic [7:0]  old_data;
    logic [7:0]  lock_byte;
    logic [23:0] code;
    logic [23:0] ref_code;
    logic        pass;
  } szac_req_t;
  typedef struct packed {
    logic       page_lock;
    logic       mod_forbid;
    logic       prog_only;
    logic       enc_req;
    logic       pwd_en;
    logic [2:0] pwd_set;
    logic       auth_en;
    logic [1:0] key;
  } szac_zcfg_t;
  typedef struct packed {
    logic       ok;
    logic [7:0] data;
    logic       auth_code_on;
    logic       crypt;
  } szac_rsp_t;
endpackage

// ==== szac_core.sv ====
// Purpose: access rights and security state of a secure serial EEPROM
// Assumes: link framing and cipher sit outside; they hand over one
//          decoded request per byte or check, with compare results
// Notes:   attempt counters live in flops here, not in NVM
// Behaviour
// - anti-tearing writes limited to eight bytes
// - anti-tearing writes go to buffer, then destination
// - pending buffer restored automatically after power-up
// - page lowest byte guards its 8-byte page
// - zero bit n blocks writes to byte n
// - bit 0 zero locks the guard byte itself
// - guard byte bits only go one to zero
// - page-lock zone writes only first byte
// - password holds until reset or new one
// - eight sets, one active, write grants read
// - four keys; failed new attempt cancels success
// - four consecutive failures disable that set
// - standard mode offers modification detection checksum
// - auth code mismatch abandons command, drops mode
// - encryption covers read, write, password data
// - encryption-required zone refused unless encryption active
// - supervisor password opens configuration access
// - modify-forbidden rejects writes; program-only clears bits
// - configuration closed until secure code verified or supervisor password held
// - power-up starts in standard security mode
`timescale 1ns/1ns
`include "szac_defines.svh"
module szac_core (
  input  wire logic                 clk_in,
  input  wire logic                 rst_b_in,
  input  wire logic                 link_clk_in,
  input  wire logic                 card_rst_b_in,
  input  wire logic                 tear_pending_in,
  input  wire logic                 anti_tear_en_in,
  input  wire logic                 supervisor_en_in,
  input  wire logic [2:0]           supervisor_set_in,
  input  wire szac_pkg::szac_zcfg_t zcfg_in,
  input  wire logic                 req_valid_in,
  input  wire szac_pkg::szac_req_t  req_in,
  input  wire logic                 nvm_done_in,
  output logic                      req_ready_out,
  output logic                      rsp_valid_out,
  output szac_pkg::szac_rsp_t       rsp_out,
  output logic                      nvm_go_out,
  output szac_pkg::szac_nvm_op_t    nvm_op_out,
  output szac_pkg::szac_mode_t      mode_out,
  output logic                      cfg_open_out,
  output logic                      pwd_admin_out,
  output logic                      busy_out,
  output logic [11:0]               try_locked_out
);
  // Pin synchronisers and link wake-up count
  logic       lclk_meta_reg, lclk_meta_next;
  logic       lclk_reg, lclk_next;
  logic       lclk_prev_reg, lclk_prev_next;
  logic       crst_meta_reg, crst_meta_next;
  logic       crst_reg, crst_next;
  logic [2:0] wake_reg, wake_next;
  logic       woke;
  logic       card_rst;

  always_comb begin
    lclk_meta_next = link_clk_in;
    lclk_next      = lclk_meta_reg;
    lclk_prev_next = lclk_reg;
    crst_meta_next = card_rst_b_in;
    crst_next      = crst_meta_reg;
    wake_next      = wake_reg;
    // Host must clock the link a few times before the first command
    if (!crst_reg) begin
      wake_next = 3'h0;
    end else if (lclk_reg && !lclk_prev_reg && !woke) begin
      wake_next = 3'(wake_reg + 3'h1);
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      lclk_meta_reg <= 1'b0;
      lclk_reg      <= 1'b0;
      lclk_prev_reg <= 1'b0;
      crst_meta_reg <= 1'b1;
      crst_reg      <= 1'b1;
      wake_reg      <= 3'h0;
    end else begin
      lclk_meta_reg <= lclk_meta_next;
      lclk_reg      <= lclk_next;
      lclk_prev_reg <= lclk_prev_next;
      crst_meta_reg <= crst_meta_next;
      crst_reg      <= crst_next;
      wake_reg      <= wake_next;
    end
  end

  assign woke     = (wake_reg == `SZAC_LINK_WAKE);
  assign card_rst = !crst_reg;

  // Security state registers
  logic                 pwd_valid_reg, pwd_valid_next;
  logic [2:0]           pwd_set_reg, pwd_set_next;
  logic                 pwd_rd_reg, pwd_rd_next;
  logic                 auth_valid_reg, auth_valid_next;
  logic [1:0]           auth_key_reg, auth_key_next;
  szac_pkg::szac_mode_t mode_reg, mode_next;
  logic                 cfg_open_reg, cfg_open_next;
  logic                 rsp_valid_reg, rsp_valid_next;
  szac_pkg::szac_rsp_t  rsp_reg, rsp_next;

  // Attempt counters: 8 password sets, then 4 keys
  logic [2:0] try_reg [`SZAC_TRY_CNTS];
  logic [2:0] try_next [`SZAC_TRY_CNTS];
  logic [3:0] try_idx;
  logic       try_upd;
  logic       try_bad;

  // Anti-tearing sequencer
  szac_pkg::szac_at_state_t at_reg, at_next;
  szac_pkg::szac_nvm_op_t   nop_reg, nop_next;
  logic                     go_reg, go_next;
  logic [3:0]               cnt_reg, cnt_next;
  logic                     any_reg, any_next;
  logic                     start_reg, start_next;

  // Access decisions, pure combinational
  logic       take;
  logic       rd_ok;
  logic       wr_ok;
  logic       pwd_rd_ok;
  logic       pwd_wr_ok;
  logic       auth_ok;
  logic       enc_ok;
  logic       lock_ok;
  logic       cnt_ok;
  logic       prog;
  logic [7:0] wr_data;
  logic       admin;

  assign busy_out      = (at_reg != szac_pkg::AT_IDLE) || start_reg;
  assign req_ready_out = woke && !busy_out && !card_rst;
  assign take          = req_valid_in && req_ready_out;
  assign admin = supervisor_en_in && pwd_valid_reg && !pwd_rd_reg &&
                 (pwd_set_reg == supervisor_set_in);

  always_comb begin
    // Either password of the set opens reads of the zone
    pwd_rd_ok = !zcfg_in.pwd_en ||
                (pwd_valid_reg && pwd_set_reg == zcfg_in.pwd_set);
    pwd_wr_ok = pwd_rd_ok && (!zcfg_in.pwd_en || !pwd_rd_reg);
    auth_ok   = !zcfg_in.auth_en ||
                (auth_valid_reg && auth_key_reg == zcfg_in.key);
    // Unrequired zones simply pass in any mode
    enc_ok    = !zcfg_in.enc_req ||
                mode_reg == szac_pkg::MODE_ENC;
    // Index 0 picks bit 0, which guards the guard byte itself
    lock_ok   = !zcfg_in.page_lock ||
                (req_in.first &&
                 req_in.lock_byte[req_in.addr_lo]);
    cnt_ok    = !anti_tear_en_in || req_in.first ||
                cnt_reg < `SZAC_AT_MAX;
    rd_ok     = pwd_rd_ok && auth_ok && enc_ok;
    wr_ok     = !zcfg_in.mod_forbid && pwd_wr_ok && auth_ok && enc_ok &&
                lock_ok && cnt_ok;
    prog      = zcfg_in.prog_only ||
                (zcfg_in.page_lock && req_in.addr_lo == 3'h0);
    wr_data   = prog ? (req_in.data & req_in.old_data)
                     : req_in.data;
  end

  always_comb begin
    pwd_valid_next  = pwd_valid_reg;
    pwd_set_next    = pwd_set_reg;
    pwd_rd_next     = pwd_rd_reg;
    auth_valid_next = auth_valid_reg;
    auth_key_next   = auth_key_reg;
    mode_next       = mode_reg;
    cfg_open_next   = cfg_open_reg;
    rsp_valid_next  = 1'b0;
    rsp_next        = rsp_reg;
    try_idx         = 4'h0;
    try_upd         = 1'b0;
    try_bad         = 1'b0;
    if (card_rst) begin
      // Reset pin drops every granted right
      pwd_valid_next  = 1'b0;
      auth_valid_next = 1'b0;
      mode_next       = szac_pkg::MODE_STD;
      cfg_open_next   = 1'b0;
    end else if (take) begin
      rsp_valid_next   = 1'b1;
      rsp_next.ok      = 1'b0;
      rsp_next.data    = req_in.data;
      unique case (req_in.op)
        szac_pkg::OP_READ: begin
          rsp_next.ok = rd_ok;
        end
        szac_pkg::OP_WRITE: begin
          rsp_next.ok   = wr_ok;
          rsp_next.data = wr_data;
        end
        szac_pkg::OP_PWD: begin
          try_idx = {1'b0, req_in.set};
          if (!try_locked_out[try_idx]) begin
            try_upd         = 1'b1;
            try_bad         = req_in.code != req_in.ref_code;
            rsp_next.ok     = !try_bad;
            // A new presentation replaces the old one, pass or fail
            pwd_valid_next  = !try_bad;
            pwd_set_next    = req_in.set;
            pwd_rd_next     = req_in.rd_pwd;
          end
        end
        szac_pkg::OP_AUTH: begin
          try_idx = `SZAC_KEY_BASE | {2'h0, req_in.set[1:0]};
          if (!try_locked_out[try_idx]) begin
            try_upd         = 1'b1;
            try_bad         = !req_in.pass;
            rsp_next.ok     = req_in.pass;
            auth_valid_next = req_in.pass;
            auth_key_next   = req_in.set[1:0];
            if (!req_in.pass) begin
              mode_next = szac_pkg::MODE_STD;
            end else if (req_in.want_enc) begin
              mode_next = szac_pkg::MODE_ENC;
            end else begin
              mode_next = szac_pkg::MODE_AUTH;
            end
          end
        end
        szac_pkg::OP_MACCHK: begin
          // Standard mode: host checks the MDC itself
          rsp_next.ok = mode_reg == szac_pkg::MODE_STD ||
                        req_in.pass;
          if (mode_reg != szac_pkg::MODE_STD && !req_in.pass) begin
            mode_next       = szac_pkg::MODE_STD;
            auth_valid_next = 1'b0;
          end
        end
        szac_pkg::OP_SECURE: begin
          cfg_open_next = req_in.code == `SZAC_SECURE_CODE;
          rsp_next.ok   = cfg_open_next;
        end
        szac_pkg::OP_CFG_RD,
        szac_pkg::OP_CFG_WR: begin
          rsp_next.ok = cfg_open_reg || admin;
        end
      endcase
      rsp_next.auth_code_on = mode_next != szac_pkg::MODE_STD;
      rsp_next.crypt        = mode_reg == szac_pkg::MODE_ENC;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pwd_valid_reg  <= 1'b0;
      pwd_set_reg    <= 3'h0;
      pwd_rd_reg     <= 1'b0;
      auth_valid_reg <= 1'b0;
      auth_key_reg   <= 2'h0;
      mode_reg       <= szac_pkg::MODE_STD;
      cfg_open_reg   <= 1'b0;
      rsp_valid_reg  <= 1'b0;
      rsp_reg        <= '0;
    end else begin
      pwd_valid_reg  <= pwd_valid_next;
      pwd_set_reg    <= pwd_set_next;
      pwd_rd_reg     <= pwd_rd_next;
      auth_valid_reg <= auth_valid_next;
      auth_key_reg   <= auth_key_next;
      mode_reg       <= mode_next;
      cfg_open_reg   <= cfg_open_next;
      rsp_valid_reg  <= rsp_valid_next;
      rsp_reg        <= rsp_next;
    end
  end

  // Success clears a counter; a saturated one no longer moves
  for (genvar i = 0; i < `SZAC_TRY_CNTS; i++) begin : g_try
    always_comb begin
      try_next[i] = try_reg[i];
      if (try_upd && try_idx == 4'(i)) begin
        try_next[i] = try_bad ? 3'(try_reg[i] + 3'h1) : 3'h0;
      end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        try_reg[i] <= 3'h0;
      end else begin
        try_reg[i] <= try_next[i];
      end
    end

    assign try_locked_out[i] = try_reg[i] == `SZAC_TRY_LIMIT;
  end

  always_comb begin
    at_next    = at_reg;
    nop_next   = nop_reg;
    go_next    = 1'b0;
    cnt_next   = cnt_reg;
    any_next   = any_reg;
    start_next = 1'b0;
    unique case (at_reg)
      szac_pkg::AT_IDLE: begin
        if (start_reg) begin
          // Buffer flag sampled once, on the first edge after reset
          if (tear_pending_in) begin
            at_next  = szac_pkg::AT_RECOVER;
            nop_next = szac_pkg::NVM_RESTORE;
            go_next  = 1'b1;
          end
        end else if (take && req_in.op == szac_pkg::OP_WRITE &&
                     anti_tear_en_in) begin
          cnt_next = req_in.first ? 4'h1 : 4'(cnt_reg + 4'h1);
          any_next = (any_reg && !req_in.first) || wr_ok;
          if (req_in.last && ((any_reg && !req_in.first) || wr_ok)) begin
            at_next  = szac_pkg::AT_BUF;
            nop_next = szac_pkg::NVM_TO_BUF;
            go_next  = 1'b1;
            any_next = 1'b0;
          end
        end
      end
      szac_pkg::AT_BUF: begin
        if (nvm_done_in) begin
          at_next  = szac_pkg::AT_COPY;
          nop_next = szac_pkg::NVM_TO_DEST;
          go_next  = 1'b1;
        end
      end
      szac_pkg::AT_COPY,
      szac_pkg::AT_RECOVER: begin
        if (nvm_done_in) begin
          at_next  = szac_pkg::AT_IDLE;
          nop_next = szac_pkg::NVM_NONE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      at_reg    <= szac_pkg::AT_IDLE;
      nop_reg   <= szac_pkg::NVM_NONE;
      go_reg    <= 1'b0;
      cnt_reg   <= 4'h0;
      any_reg   <= 1'b0;
      start_reg <= 1'b1;
    end else begin
      at_reg    <= at_next;
      nop_reg   <= nop_next;
      go_reg    <= go_next;
      cnt_reg   <= cnt_next;
      any_reg   <= any_next;
      start_reg <= start_next;
    end
  end

  assign rsp_valid_out = rsp_valid_reg;
  assign rsp_out       = rsp_reg;
  assign nvm_go_out    = go_reg;
  assign nvm_op_out    = nop_reg;
  assign mode_out      = mode_reg;
  assign cfg_open_out  = cfg_open_reg;
  assign pwd_admin_out = admin;
endmodule

// ==== szac_core_asserts.sv ====
// Purpose: port checks of the secure zone access control core
// Assumes: bound to szac_core, one clock domain
// Notes:   tk marks a request taken at the edge
`timescale 1ns/1ns
module szac_core_asserts (
  input wire logic                   clk_in,
  input wire logic                   rst_b_in,
  input wire szac_pkg::szac_zcfg_t   zcfg_in,
  input wire logic                   req_valid_in,
  input wire szac_pkg::szac_req_t    req_in,
  input wire logic                   nvm_done_in,
  input wire logic                   req_ready_out,
  input wire logic                   rsp_valid_out,
  input wire szac_pkg::szac_rsp_t    rsp_out,
  input wire logic                   nvm_go_out,
  input wire szac_pkg::szac_nvm_op_t nvm_op_out,
  input wire szac_pkg::szac_mode_t   mode_out,
  input wire logic                   cfg_open_out,
  input wire logic                   busy_out,
  input wire logic [11:0]            try_locked_out
);
  logic       tk;
  logic       wr;
  logic       pl;
  logic       sc_ok;
  logic [7:0] masked;
  assign tk = req_valid_in && req_ready_out;
  assign wr = tk && req_in.op == szac_pkg::OP_WRITE;
  assign pl = wr && zcfg_in.page_lock;
  assign masked = req_in.data & req_in.old_data;
  assign sc_ok = tk && req_in.op == szac_pkg::OP_SECURE
                 && req_in.code == 24'h22ef67;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  sequence s_buf_done;
    nvm_done_in && nvm_op_out == szac_pkg::NVM_TO_BUF;
  endsequence
  sequence s_dest_go;
    nvm_go_out && nvm_op_out == szac_pkg::NVM_TO_DEST;
  endsequence
  a_rsp_follows: assert property (tk |=> rsp_valid_out)
    else $error("no response after a taken request");
  a_busy_no_take: assert property (busy_out |-> !req_ready_out)
    else $error("request ready while busy");
  a_tear_copy: assert property (s_buf_done |=> s_dest_go)
    else $error("no copy to destination after buffer write");
  a_forbid_write: assert property (
    wr && zcfg_in.mod_forbid |=> !rsp_out.ok)
    else $error("write accepted in modify-forbidden zone");
  a_prog_only_mask: assert property (
    wr && zcfg_in.prog_only |=> !rsp_out.ok || rsp_out.data == $past(masked))
    else $error("program-only write set a bit");
  a_lock_bit: assert property (pl && req_in.addr_lo != 3'h0
    && !req_in.lock_byte[req_in.addr_lo] |=> !rsp_out.ok)
    else $error("write to locked byte accepted");
  a_guard_self: assert property (pl && req_in.addr_lo == 3'h0
    && !req_in.lock_byte[0] |=> !rsp_out.ok)
    else $error("locked guard byte written");
  a_first_only: assert property (pl && !req_in.first |=> !rsp_out.ok)
    else $error("later byte written in page-lock zone");
  a_enc_required: assert property (tk && zcfg_in.enc_req
    && (req_in.op == szac_pkg::OP_READ || req_in.op == szac_pkg::OP_WRITE)
    && mode_out != szac_pkg::MODE_ENC |=> !rsp_out.ok)
    else $error("plain access to encryption-required zone");
  a_code_fail_drop: assert property (tk
    && req_in.op == szac_pkg::OP_MACCHK && !req_in.pass
    && mode_out != szac_pkg::MODE_STD
    |=> mode_out == szac_pkg::MODE_STD && !rsp_out.ok)
    else $error("secured mode kept after bad checksum");
  a_try_sticky: assert property (
    (try_locked_out & $past(try_locked_out)) == $past(try_locked_out))
    else $error("attempt lock released");
  a_cfg_by_code: assert property (
    $rose(cfg_open_out) |-> $past(sc_ok))
    else $error("configuration opened without secure code");
endmodule
bind szac_core szac_core_asserts chk_u (.*);

// ==== szac_nvm_link_model.sv ====
// Purpose: host side link clock and NVM completion model
// Assumes: driven from the bench at falling edges
// Notes:   slow_in stretches the NVM write time
`timescale 1ns/1ns
module szac_nvm_link_model (
  input  wire logic clk_in,
  input  wire logic nvm_go_in,
  input  wire logic link_run_in,
  input  wire logic slow_in,
  output logic      nvm_done_out,
  output logic      link_clk_out
);
  logic [4:0] cnt;
  // Link clock stands low outside host traffic
  initial begin
    cnt = 5'h0;
    nvm_done_out = 1'b0;
    link_clk_out = 1'b0;
    forever begin
      wait (link_run_in);
      #63 link_clk_out = 1'b1;
      #62 link_clk_out = 1'b0;
    end
  end
  always @(posedge clk_in) begin
    nvm_done_out <= cnt == 5'h1;
    if (nvm_go_in)
      cnt <= slow_in ? 5'h14 : 5'h2;
    else if (cnt != 5'h0)
      cnt <= cnt - 5'h1;
  end
endmodule

// ==== test_secure_zone_access_control.sv ====
// Purpose: self-checking bench of the secure zone access control core
// Assumes: inputs change at falling edges
// Notes:   responses are captured at the falling edge after the taking edge
`timescale 1ns/1ns
module test_secure_zone_access_control;
  localparam szac_pkg::szac_op_t RD = szac_pkg::OP_READ;
  localparam szac_pkg::szac_op_t WR = szac_pkg::OP_WRITE;
  localparam szac_pkg::szac_op_t PW = szac_pkg::OP_PWD;
  localparam szac_pkg::szac_op_t AU = szac_pkg::OP_AUTH;
  localparam szac_pkg::szac_op_t MC = szac_pkg::OP_MACCHK;
  localparam szac_pkg::szac_op_t SC = szac_pkg::OP_SECURE;
  localparam szac_pkg::szac_op_t CR = szac_pkg::OP_CFG_RD;
  localparam logic [23:0]        REF = 24'h5a3c96;
  logic                   clk, rst_b, link_clk, tear, at_en, sup_en;
  logic                   valid, done, go, ready, rv, cfg, adm, busy;
  logic                   run, slow, crst_b;
  logic [2:0]             sup_set;
  logic [7:0]             lk;
  logic [11:0]            tl;
  szac_pkg::szac_zcfg_t   zc;
  szac_pkg::szac_req_t    rq;
  szac_pkg::szac_rsp_t    rsp, got;
  szac_pkg::szac_nvm_op_t nop, op_r;
  szac_pkg::szac_mode_t   mode;
  int                     n_fail, cmp_count;
  szac_core dut_u (.clk_in(clk), .rst_b_in(rst_b), .link_clk_in(link_clk),
    .card_rst_b_in(crst_b), .tear_pending_in(tear), .anti_tear_en_in(at_en),
    .supervisor_en_in(sup_en), .supervisor_set_in(sup_set), .zcfg_in(zc),
    .req_valid_in(valid), .req_in(rq), .nvm_done_in(done),
    .req_ready_out(ready), .rsp_valid_out(rv), .rsp_out(rsp),
    .nvm_go_out(go), .nvm_op_out(nop), .mode_out(mode),
    .cfg_open_out(cfg), .pwd_admin_out(adm), .busy_out(busy),
    .try_locked_out(tl));
  szac_nvm_link_model hm_u (.clk_in(clk), .nvm_go_in(go),
    .link_run_in(run), .slow_in(slow), .nvm_done_out(done),
    .link_clk_out(link_clk));
  task automatic chk(input string n, input logic [11:0] e, g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic send(input szac_pkg::szac_op_t op, input logic [2:0] s,
      input logic [7:0] d, o, input logic [2:0] a,
      input logic f, l, p, e, input logic [23:0] c);
    int k;
    @(negedge clk);
    rq = '{op, s, 1'b0, e, a, f, l, d, o, lk, c, REF, p};
    valid = 1'b1;
    k = 0;
    while (ready !== 1'b1 && k < 5000) begin
      @(negedge clk);
      k++;
    end
    @(posedge clk);
    @(negedge clk);
    valid = 1'b0;
    got = rsp;
    op_r = nop;
    chk("rsp valid", 1, rv);
  endtask
  task automatic summarize();
    if (n_fail == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic t_wake();
    int k;
    k = 0;
    while (nop !== szac_pkg::NVM_RESTORE && k < 10) begin
      @(negedge clk);
      k++;
    end
    chk("restore op", szac_pkg::NVM_RESTORE, nop);
    chk("restore go", 1, go);
    chk("mode", szac_pkg::MODE_STD, mode);
    chk("cfg open", 0, cfg);
    tear = 1'b0;
    run = 1'b1;
    k = 0;
    while (ready !== 1'b1 && k < 2000) begin
      @(negedge clk);
      k++;
    end
    run = 1'b0;
    chk("ready", 1, ready);
  endtask
  task automatic t_lock();
    zc = '0;
    zc.page_lock = 1'b1;
    lk = 8'hd9;
    for (int a = 1; a < 8; a++) begin
      send(WR, 0, 8'ha5, 8'hff, 3'(a), 1, 1, 0, 0, 0);
      chk("lock ok", lk[a], got.ok);
    end
    send(WR, 0, 8'h5a, 8'hd9, 0, 1, 1, 0, 0, 0);
    chk("guard data", 8'h58, got.data);
    send(WR, 0, 8'h11, 8'hff, 3, 0, 1, 0, 0, 0);
    chk("later byte", 0, got.ok);
    lk = 8'hd8;
    send(WR, 0, 8'h00, 8'hd8, 0, 1, 1, 0, 0, 0);
    chk("guard locked", 0, got.ok);
  endtask
  task automatic t_zone();
    zc = '0;
    zc.mod_forbid = 1'b1;
    send(WR, 0, 8'h12, 8'hff, 0, 1, 1, 0, 0, 0);
    chk("forbid ok", 0, got.ok);
    zc = '0;
    zc.prog_only = 1'b1;
    send(WR, 0, 8'hf0, 8'h3c, 0, 1, 1, 0, 0, 0);
    chk("prog data", 8'h30, got.data);
  endtask
  task automatic t_cfg();
    send(CR, 0, 0, 0, 0, 1, 1, 0, 0, 0);
    chk("cfg closed", 0, got.ok);
    send(SC, 0, 0, 0, 0, 1, 1, 0, 0, 24'h22ef66);
    chk("bad code", 0, cfg);
    send(SC, 0, 0, 0, 0, 1, 1, 0, 0, 24'h22ef67);
    send(CR, 0, 0, 0, 0, 1, 1, 0, 0, 0);
    chk("cfg read", 1, got.ok);
  endtask
  task automatic t_pwd();
    zc = '0;
    zc.pwd_en = 1'b1;
    zc.pwd_set = 3'h2;
    send(PW, 2, 0, 0, 0, 1, 1, 0, 0, REF);
    send(RD, 0, 0, 0, 0, 1, 1, 0, 0, 0);
    chk("write pwd read", 1, got.ok);
    send(PW, 3, 0, 0, 0, 1, 1, 0, 0, REF);
    send(RD, 0, 0, 0, 0, 1, 1, 0, 0, 0);
    chk("other set read", 0, got.ok);
    for (int i = 0; i < 4; i++)
      send(PW, 5, 0, 0, 0, 1, 1, 0, 0, 24'h000001);
    chk("set locked", 1, tl[5]);
    send(PW, 5, 0, 0, 0, 1, 1, 0, 0, REF);
    chk("locked try", 0, got.ok);
    sup_en = 1'b1;
    send(PW, 7, 0, 0, 0, 1, 1, 0, 0, REF);
    chk("supervisor", 1, adm);
  endtask
  task automatic t_card();
    int k;
    @(negedge clk);
    crst_b = 1'b0;
    repeat (4) @(negedge clk);
    chk("card rst admin", 0, adm);
    chk("card rst cfg", 0, cfg);
    chk("card rst ready", 0, ready);
    crst_b = 1'b1;
    run = 1'b1;
    k = 0;
    while (ready !== 1'b1 && k < 2000) begin
      @(negedge clk);
      k++;
    end
    run = 1'b0;
    chk("rewake ready", 1, ready);
  endtask
  task automatic t_auth();
    zc = '0;
    zc.auth_en = 1'b1;
    zc.key = 2'h1;
    zc.enc_req = 1'b1;
    send(AU, 1, 0, 0, 0, 1, 1, 1, 1, 0);
    chk("enc mode", szac_pkg::MODE_ENC, mode);
    send(RD, 0, 0, 0, 0, 1, 1, 0, 0, 0);
    chk("enc read", 1, got.ok);
    chk("crypt", 1, got.crypt);
    send(MC, 0, 0, 0, 0, 1, 1, 0, 0, 0);
    chk("mac fail", 0, got.ok);
    chk("mode drop", szac_pkg::MODE_STD, mode);
    send(RD, 0, 0, 0, 0, 1, 1, 0, 0, 0);
    chk("plain read", 0, got.ok);
    send(MC, 0, 0, 0, 0, 1, 1, 0, 0, 0);
    chk("std check", 1, got.ok);
    zc.enc_req = 1'b0;
    send(AU, 1, 0, 0, 0, 1, 1, 1, 1, 0);
    chk("opt enc", szac_pkg::MODE_ENC, mode);
    send(AU, 1, 0, 0, 0, 1, 1, 1, 0, 0);
    chk("auth mode", szac_pkg::MODE_AUTH, mode);
    chk("auth code on", 1, got.auth_code_on);
    send(AU, 1, 0, 0, 0, 1, 1, 0, 0, 0);
    send(RD, 0, 0, 0, 0, 1, 1, 0, 0, 0);
    chk("auth lost", 0, got.ok);
  endtask
  task automatic t_tear(input int n);
    int k;
    at_en = 1'b1;
    zc = '0;
    for (int i = 0; i < n; i++) begin
      send(WR, 0, 8'(i), 8'hff, 3'(i), i == 0, i == n - 1, 0, 0, 0);
      chk("tear ok", i < 8, got.ok);
    end
    if (n == 8)
      chk("to buffer", szac_pkg::NVM_TO_BUF, op_r);
    k = 0;
    while (nop !== szac_pkg::NVM_TO_DEST && k < 100) begin
      @(negedge clk);
      k++;
    end
    chk("to dest", szac_pkg::NVM_TO_DEST, nop);
    chk("dest go", 1, go);
    chk("busy copy", 1, busy);
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #200000;
    n_fail++;
    summarize();
  end
  initial begin
    {rst_b, at_en, sup_en, valid, run, slow} = '0;
    tear = 1'b1;
    crst_b = 1'b1;
    sup_set = 3'h7;
    zc = '0;
    rq = '0;
    lk = 8'hff;
    n_fail = 0;
    cmp_count = 0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    t_wake();
    t_lock();
    t_zone();
    t_cfg();
    t_pwd();
    t_card();
    t_auth();
    t_tear(8);
    slow = 1'b1;
    t_tear(9);
    summarize();
  end
endmodule
